//--- verilog/period_timer_consts.vh
`ifndef PERIOD_TIMER_CONSTS_VH
`define PERIOD_TIMER_CONSTS_VH
// register byte addresses on the bus
`define ADDR_PERIOD_COUNTER 12'h000
`define ADDR_PERIOD_LIMIT 12'h004
`define ADDR_CONTROL 12'h008
`define ADDR_FLAG 12'h00c
`define ADDR_IRQ_ENABLE 12'h010
// control field positions
`define POSTSCALE_HI 6
`define POSTSCALE_LO 3
`define TIMER_ON_BIT 2
`define PRESCALE_HI 1
`define PRESCALE_LO 0
// flag and enable register bit
`define MATCH_FLAG_BIT 1
// reset values
`define COUNTER_RESET 8'h00
`define LIMIT_RESET 8'hff
`define CONTROL_RESET 7'h00
// instruction clock is the core clock divided by this plus one
`define INSTR_DIV 2'd3
`define INSTR_DIV_W 2
// prescaler terminal counts, ratio minus one
`define PRE_DIV1 6'h00
`define PRE_DIV4 6'h03
`define PRE_DIV16 6'h0f
`define PRE_DIV64 6'h3f
`endif

//--- verilog/period_prescaler.v
`timescale 1ns/1ns
`default_nettype none
`include "period_timer_consts.vh"
module period_prescaler (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire tick,
  input wire clear,
  input wire [1:0] select,
  // output
  output reg pulse
);
  reg [5:0] count;

  // terminal count for the selected ratio
  function [5:0] limit_of;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: limit_of = `PRE_DIV1;
        2'b01: limit_of = `PRE_DIV4;
        2'b10: limit_of = `PRE_DIV16;
        default: limit_of = `PRE_DIV64;
      endcase
    end
  endfunction

  // divide instruction ticks down
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 6'h00;
      pulse <= 1'b0;
    end else if (clear) begin
      count <= 6'h00;
      pulse <= 1'b0;
    end else if (tick) begin
      if (count >= limit_of(select)) begin
        count <= 6'h00;
        pulse <= 1'b1;
      end else begin
        count <= count + 6'h01;
        pulse <= 1'b0;
      end
    end else begin
      pulse <= 1'b0;
    end
  end
endmodule // period_prescaler
`default_nettype wire

//--- verilog/period_match_timer.v
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "period_timer_consts.vh"
module period_match_timer (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // status out
  output reg period_match_flag,
  output reg match_pulse
);
  reg rst_meta;
  reg rst_sync_n;
  reg [`INSTR_DIV_W-1:0] instr_count;
  reg instr_tick;
  reg [7:0] period_counter;
  reg [7:0] period_limit;
  reg [6:0] period_timer_control;
  reg period_match_irq_enable;
  reg [3:0] post_count;
  reg [31:0] next_prdata;
  reg addr_ok;
  wire pre_pulse;
  wire wr_access;
  wire wr_counter;
  wire wr_control;
  wire hidden_clear;
  wire timer_on;
  wire at_match;
  wire step;
  wire post_out;
  wire [3:0] post_select;

  // reset release through two flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // bus decode
  assign wr_access = psel & penable & pwrite;
  assign wr_counter = wr_access & (paddr == `ADDR_PERIOD_COUNTER);
  assign wr_control = wr_access & (paddr == `ADDR_CONTROL);
  assign hidden_clear = wr_counter | wr_control;
  assign timer_on = period_timer_control[`TIMER_ON_BIT];
  assign post_select = period_timer_control[`POSTSCALE_HI:`POSTSCALE_LO];
  assign at_match = (period_counter == period_limit);
  assign step = pre_pulse & timer_on & ~hidden_clear;
  assign post_out = step & at_match & (post_count == post_select);

  // instruction clock enable, one pulse every four core cycles
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      instr_count <= {`INSTR_DIV_W{1'b0}};
      instr_tick <= 1'b0;
    end else if (instr_count == `INSTR_DIV) begin
      instr_count <= {`INSTR_DIV_W{1'b0}};
      instr_tick <= 1'b1;
    end else begin
      instr_count <= instr_count + 2'd1;
      instr_tick <= 1'b0;
    end
  end

  // prescaler, stalled while the timer is off
  period_prescaler u_prescaler (
    .clk(clk),
    .rst_n(rst_sync_n),
    .tick(instr_tick & timer_on),
    .clear(hidden_clear),
    .select(period_timer_control[`PRESCALE_HI:`PRESCALE_LO]),
    .pulse(pre_pulse)
  );

  // period counter and limit
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      period_counter <= `COUNTER_RESET;
      period_limit <= `LIMIT_RESET;
    end else begin
      if (wr_counter) begin
        period_counter <= pwdata[7:0];
      end else if (step) begin
        if (at_match) begin
          period_counter <= 8'h00;
        end else begin
          period_counter <= period_counter + 8'h01;
        end
      end
      if (wr_access & (paddr == `ADDR_PERIOD_LIMIT)) begin
        period_limit <= pwdata[7:0];
      end
    end
  end

  // postscaler count
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      post_count <= 4'h0;
    end else if (hidden_clear) begin
      post_count <= 4'h0;
    end else if (step & at_match) begin
      if (post_count == post_select) begin
        post_count <= 4'h0;
      end else begin
        post_count <= post_count + 4'h1;
      end
    end
  end

  // control, flag and enable registers
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      period_timer_control <= `CONTROL_RESET;
      period_match_flag <= 1'b0;
      period_match_irq_enable <= 1'b0;
      match_pulse <= 1'b0;
    end else begin
      match_pulse <= step & at_match;
      if (wr_control) begin
        period_timer_control <= pwdata[6:0];
      end
      if (wr_access & (paddr == `ADDR_IRQ_ENABLE)) begin
        period_match_irq_enable <= pwdata[`MATCH_FLAG_BIT];
      end
      // set wins over a software clear
      if (post_out) begin
        period_match_flag <= 1'b1;
      end else if (wr_access & (paddr == `ADDR_FLAG)) begin
        period_match_flag <= pwdata[`MATCH_FLAG_BIT];
      end
    end
  end

  // read mux
  always @* begin
    next_prdata = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
      `ADDR_PERIOD_COUNTER: next_prdata[7:0] = period_counter;
      `ADDR_PERIOD_LIMIT: next_prdata[7:0] = period_limit;
      `ADDR_CONTROL: next_prdata[6:0] = period_timer_control;
      `ADDR_FLAG: next_prdata[`MATCH_FLAG_BIT] = period_match_flag;
      `ADDR_IRQ_ENABLE:
        next_prdata[`MATCH_FLAG_BIT] = period_match_irq_enable;
      default: addr_ok = 1'b0;
    endcase
  end

  // apb answer, registered so access phase always lasts one cycle
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel & ~penable) begin
      pready <= 1'b1;
      pslverr <= ~addr_ok;
      prdata <= pwrite ? 32'h00000000 : next_prdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end
endmodule // period_match_timer
`default_nettype wire

//--- testbench/period_match_timer_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module period_match_timer_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // status
  input wire logic period_match_flag,
  input wire logic match_pulse
);
  // completed software write to the flag register
  wire flag_wr = psel && penable && pready && pwrite && paddr == 12'h00c;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_err; pslverr && !pwrite |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error read");
  property p_map; pready && paddr <= 12'h010 && paddr[1:0] == 2'h0
    |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("mapped access refused");
  property p_ctl; pready && !pwrite && paddr == 12'h008
    |-> prdata[31:7] == 25'h0; endproperty
  a_ctl: assert property (p_ctl) else $error("control top bits set");
  property p_cnt; pready && !pwrite && paddr == 12'h000
    |-> prdata[31:8] == 24'h0; endproperty
  a_cnt: assert property (p_cnt) else $error("counter wider than 8");
  property p_gap; match_pulse |=> !match_pulse [*3]; endproperty
  a_gap: assert property (p_gap) else $error("matches too close");
  property p_stk; period_match_flag && !flag_wr |=> period_match_flag;
  endproperty
  a_stk: assert property (p_stk) else $error("flag dropped alone");
endmodule // period_match_timer_monitor
bind period_match_timer period_match_timer_monitor mon (.clk(clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .period_match_flag(period_match_flag),
  .match_pulse(match_pulse));
`default_nettype wire

//--- testbench/period_match_timer_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module period_match_timer_tb;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic rerr;
  logic [3:0] post;
  logic [1:0] ps;
  wire [31:0] prdata;
  wire pready, pslverr, period_match_flag, match_pulse;
  int error_cnt = 0, checks = 0, seed = 63160, cnt, i, p, lim, t0, t1;
  // 25 MHz clock
  always #20 clk = ~clk;
  period_match_timer uut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .period_match_flag(period_match_flag), .match_pulse(match_pulse));
  // verdict and end of run
  task finish_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one apb transfer, read data left in rd
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready) break;
    end
    if (k == 20) begin error_cnt++; finish_test; end
    rd = prdata;
    rerr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // time of next match pulse
  task wait_pulse(output int t);
    int k;
    for (k = 0; k < 20000; k++) begin
      @(posedge clk);
      if (match_pulse) break;
    end
    if (k == 20000) begin error_cnt++; finish_test; end
    t = $time / 40;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    apb(0, 12'h000, 0); `CHK("counter reset", 32'h0, rd)
    apb(0, 12'h004, 0); `CHK("limit reset", 32'hff, rd)
    apb(0, 12'h008, 0); `CHK("control reset", 32'h0, rd)
    apb(0, 12'h014, 0); `CHK("unmapped", 32'h0, rd)
    `CHK("unmapped err", 1'b1, rerr)
    apb(0, 12'h00c, 0); `CHK("mapped err", 1'b0, rerr)
    apb(1, 12'h008, 32'hff); apb(0, 12'h008, 0);
    `CHK("control bits", 32'h7f, rd)
    apb(1, 12'h008, 0); apb(1, 12'h000, 32'h5a);
    apb(1, 12'h008, 32'h78); apb(0, 12'h000, 0);
    `CHK("counter kept", 32'h5a, rd)
    for (p = 0; p < 4; p++) begin
      ps = p[1:0];
      lim = 1 + ($unsigned($random(seed)) % 3);
      post = $random(seed);
      apb(1, 12'h008, 0); apb(1, 12'h004, lim);
      apb(0, 12'h004, 0); `CHK("limit rw", lim, rd)
      apb(1, 12'h000, 0); apb(1, 12'h00c, 0);
      apb(1, 12'h008, {post, 1'b1, ps});
      cnt = 0;
      for (i = 0; i < 40000 && !period_match_flag; i++) begin
        @(posedge clk);
        if (match_pulse) cnt++;
      end
      if (!period_match_flag) begin error_cnt++; finish_test; end
      `CHK("postscale", post + 1, cnt)
      wait_pulse(t0); wait_pulse(t1);
      `CHK("period", 4 * (1 << (2 * p)) * (lim + 1), t1 - t0)
      `CHK("sticky", 1'b1, period_match_flag)
      apb(1, 12'h008, 0); apb(1, 12'h00c, 0);
      @(negedge clk);
      `CHK("flag clear", 1'b0, period_match_flag)
    end
    finish_test;
  end
endmodule // period_match_timer_tb
`default_nettype wire
